/* rtl/asc_reg_bank.sv */
`timescale 1ns/100ps
// Behaviour
// R1: Read-only bits 3:0 show cores D..A, 1 active, 0 standby.
// R2: Writing 1 to soft clear resets all configuration and logic; the link domain and the held read answer are not reset.
// R3: Soft clear bit returns to 0 by itself after one cycle.
// R4: Pattern kind select only acts while pattern mode enable is 1.
// R5: Host pulses the alignment input whenever pattern mode toggles.
// R6: Select 0 gives a shared ramp; 1 gives FF after ten 00 words.
// R7: Start-up delay field adds 0 to 15 cycles before start-up.
// R8: Pointer codes 001..100 select channels A..D.
// R9: Other pointer codes select no channel; only common registers reachable.
// R10: Host sets the pointer before touching per-channel registers.
// R11: Per-channel addresses have four copies chosen by the pointer.
// R12: Linearity code 10 loads linearity; 00, 11 idle; 01 forbidden.
// R13: Offset code 10 loads offset; other codes idle.
// R14: Gain code 10 loads gain; other codes idle.
// R15: Phase code 10 loads phase; other codes idle.
// R16: Launch write starts transfers; busy holds until all finish.
// R17: Launch fields keep their written values after transfers.
// R18: Transfers run in order linearity, gain, offset, phase.
// R19: Mailbox bit 0 reads 1 busy, 0 ready; default 0.
// R20: Launch writes to a busy channel are ignored.
// R21: Run state bit 0 shows selected channel active; default 0.
// R22: Standby select 00 none, 01 A and B, 10 C and D, 11 all.
// R23: Activity and run state follow standby select and channel config.
// R24: Read-only and unused bits ignore writes and read as zero.
module asc_reg_bank
	import asc_pkg::*;
(
	// Core clock and reset
	input wire logic clock,
	input wire logic rst,
	// Serial link from the host
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic mosi,
	output logic miso_o,
	output logic miso_oe,
	// Fields of the main control register
	input wire logic pattern_mode_en,
	input wire logic [1:0] standby_select,
	input wire logic [3:0] channel_config,
	// Alignment pulse pins
	input wire logic align_pulse_pos,
	input wire logic align_pulse_neg,
	// Calibration transfer port
	output logic xfer_valid,
	output logic [1:0] xfer_kind,
	output logic [1:0] xfer_chan,
	input wire logic xfer_done,
	// Status and test outputs
	output logic [3:0] core_active_flags,
	output logic core_started,
	output logic [31:0] test_lanes
);

	////////////////////////////////////////////////////////////////////////
	// Helpers

	function automatic logic ptr_ok(input logic [2:0] p);
		return (p >= PTR_A) && (p <= PTR_D);
	endfunction : ptr_ok

	function automatic logic [1:0] ptr_idx(input logic [2:0] p);
		return 2'(p - PTR_A);
	endfunction : ptr_idx

	// Lowest set bit wins, which also gives the service order
	function automatic logic [1:0] first_set(input logic [3:0] m);
		if (m[0])
			return 2'h0;
		else if (m[1])
			return 2'h1;
		else if (m[2])
			return 2'h2;
		return 2'h3;
	endfunction : first_set

	// Launch fields to a mask indexed by transfer kind
	function automatic logic [3:0] cal_mask(input logic [7:0] f);
		logic [3:0] m;
		m = 4'h0;
		m[XK_LIN] = f[CAL_LIN_LSB +: 2] == CAL_LOAD_CODE; // [R12]
		m[XK_OFF] = f[CAL_OFF_LSB +: 2] == CAL_LOAD_CODE; // [R13]
		m[XK_GAIN] = f[CAL_GAIN_LSB +: 2] == CAL_LOAD_CODE; // [R14]
		m[XK_PHASE] = f[CAL_PHASE_LSB +: 2] == CAL_LOAD_CODE; // [R15]
		return m;
	endfunction : cal_mask

	////////////////////////////////////////////////////////////////////////
	// Link domain (sclk)

	logic spi_rst;
	logic [5:0] bit_cnt_q;
	logic [15:0] sh_in_q;
	logic [15:0] sh_out_q;
	logic rd_cmd_q;
	logic [6:0] addr_q;
	logic [15:0] wdata_q;
	logic rd_tgl_q;
	logic wr_tgl_q;
	logic ack_s1_q;
	logic ack_s2_q;
	logic [15:0] rdata_hold_q;
	logic ack_tgl_q;

	// Deselect restarts the frame; sclk may stop between frames
	assign spi_rst = rst | cs_n;

	// Bit counter and input shifter, saturating after one frame
	always_ff @(posedge sclk or posedge spi_rst) begin
		if (spi_rst) begin
			bit_cnt_q <= 6'h00;
			sh_in_q <= 16'h0000;
		end else begin
			sh_in_q <= {sh_in_q[14:0], mosi};
			if (bit_cnt_q != SPI_FRAME_BITS)
				bit_cnt_q <= bit_cnt_q + 6'h01;
		end
	end

	// Command capture; toggles survive deselect so no event is lost
	always_ff @(posedge sclk or posedge rst) begin
		if (rst) begin
			rd_cmd_q <= 1'b0;
			addr_q <= 7'h00;
			rd_tgl_q <= 1'b0;
		end else if (bit_cnt_q == SPI_CMD_LAST) begin
			rd_cmd_q <= sh_in_q[6];
			addr_q <= {sh_in_q[5:0], mosi};
			if (sh_in_q[6])
				rd_tgl_q <= ~rd_tgl_q;
		end
	end

	// Write word capture at the last data bit
	always_ff @(posedge sclk or posedge rst) begin
		if (rst) begin
			wdata_q <= 16'h0000;
			wr_tgl_q <= 1'b0;
		end else if (bit_cnt_q == SPI_LAST && !rd_cmd_q) begin
			wdata_q <= {sh_in_q[14:0], mosi};
			wr_tgl_q <= ~wr_tgl_q;
		end
	end

	// Read acknowledge synchroniser
	always_ff @(posedge sclk or posedge rst) begin
		if (rst) begin
			ack_s1_q <= 1'b0;
			ack_s2_q <= 1'b0;
		end else begin
			ack_s1_q <= ack_tgl_q;
			ack_s2_q <= ack_s1_q;
		end
	end

	// Read word is taken only once the handshake has closed
	always_ff @(posedge sclk or posedge spi_rst) begin
		if (spi_rst)
			sh_out_q <= 16'h0000;
		else if (bit_cnt_q == SPI_TURN_LAST)
			sh_out_q <= (ack_s2_q == rd_tgl_q) ? rdata_hold_q : 16'h0000;
		else
			sh_out_q <= {sh_out_q[14:0], 1'b0};
	end

	assign miso_o = sh_out_q[15];
	assign miso_oe = !cs_n && rd_cmd_q && (bit_cnt_q >= SPI_DATA_FIRST);

	////////////////////////////////////////////////////////////////////////
	// Crossings into the core domain

	logic [2:0] wr_sync_q;
	logic [2:0] rd_sync_q;
	logic [1:0] al_pos_q;
	logic [1:0] al_neg_q;
	logic al_prev_q;
	logic wr_ev;
	logic rd_ev;
	logic al_lvl;
	logic al_ev;

	// Two flops per toggle, a third for the edge
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			wr_sync_q <= 3'h0;
			rd_sync_q <= 3'h0;
			al_pos_q <= 2'h0;
			al_neg_q <= 2'h0;
			al_prev_q <= 1'b0;
		end else begin
			wr_sync_q <= {wr_sync_q[1:0], wr_tgl_q};
			rd_sync_q <= {rd_sync_q[1:0], rd_tgl_q};
			al_pos_q <= {al_pos_q[0], align_pulse_pos};
			al_neg_q <= {al_neg_q[0], align_pulse_neg};
			al_prev_q <= al_lvl;
		end
	end

	assign wr_ev = wr_sync_q[2] ^ wr_sync_q[1];
	assign rd_ev = rd_sync_q[2] ^ rd_sync_q[1];
	assign al_lvl = al_pos_q[1] & ~al_neg_q[1];
	assign al_ev = al_lvl & ~al_prev_q; // [R5]

	////////////////////////////////////////////////////////////////////////
	// Common registers

	logic soft_q;
	logic pat_sel_q;
	logic [3:0] dly_q;
	logic [2:0] ptr_q;
	logic sel_ok;
	logic [1:0] sel_idx;

	assign sel_ok = ptr_ok(ptr_q); // [R8] [R9]
	assign sel_idx = ptr_idx(ptr_q); // [R8]

	// Soft clear lives for a single cycle, then drops itself
	always_ff @(posedge clock or posedge rst) begin
		if (rst)
			soft_q <= SOFT_RST;
		else if (soft_q)
			soft_q <= SOFT_RST; // [R3]
		else if (wr_ev && addr_q == OFS_SOFT)
			soft_q <= wdata_q[SOFT_BIT]; // [R2]
	end

	// Writable common fields; unused bits are simply not stored
	always_ff @(posedge clock or posedge rst) begin
		if (rst || soft_q) begin // [R2]
			pat_sel_q <= PAT_RST;
			dly_q <= DLY_RST;
			ptr_q <= PTR_RST;
		end else if (wr_ev) begin // [R24]
			if (addr_q == OFS_PATTERN)
				pat_sel_q <= wdata_q[PAT_BIT];
			if (addr_q == OFS_STARTUP)
				dly_q <= wdata_q[3:0];
			if (addr_q == OFS_POINTER)
				ptr_q <= wdata_q[2:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Activity flags

	logic [3:0] act_d;
	logic [3:0] act_q;

	// Interleaved modes cannot run half idle, so any standby is full
	always_comb begin
		unique case (standby_select) // [R22]
			SB_NONE: act_d = 4'hf;
			SB_AB: act_d = 4'hc;
			SB_CD: act_d = 4'h3;
			SB_ALL: act_d = 4'h0;
		endcase
		if (channel_config[3] && standby_select != SB_NONE)
			act_d = 4'h0; // [R23]
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst || soft_q)
			act_q <= 4'h0;
		else
			act_q <= act_d; // [R1] [R23]
	end

	assign core_active_flags = act_q;

	////////////////////////////////////////////////////////////////////////
	// Per-channel launch copies and pending transfers

	logic [7:0] cal_q [4];
	logic [3:0] pend_q [4];
	logic [3:0] busy;
	logic cal_wr;
	asc_xfer_st_t st_q;
	logic [1:0] kind_q;
	logic [1:0] chan_q;
	logic [1:0] pick_chan;

	always_comb begin
		for (int c = 0; c < 4; c++)
			busy[c] = |pend_q[c]; // [R16]
	end

	// Launch to a busy channel is dropped whole
	assign cal_wr = wr_ev && addr_q == OFS_CAL && sel_ok
		&& !busy[sel_idx]; // [R11] [R20]

	// Launch fields stay as written after their transfers end
	always_ff @(posedge clock or posedge rst) begin
		if (rst || soft_q) begin
			for (int c = 0; c < 4; c++)
				cal_q[c] <= CAL_RST;
		end else if (cal_wr) begin
			cal_q[sel_idx] <= wdata_q[7:0]; // [R11] [R17]
		end
	end

	// Completion clears one bit; the launch is written after it
	always_ff @(posedge clock or posedge rst) begin
		if (rst || soft_q) begin
			for (int c = 0; c < 4; c++)
				pend_q[c] <= 4'h0;
		end else begin
			if (st_q == ST_WAIT && xfer_done)
				pend_q[chan_q][kind_q] <= 1'b0;
			if (cal_wr)
				pend_q[sel_idx] <= cal_mask(wdata_q[7:0]); // [R16]
		end
	end

	assign pick_chan = first_set(busy);

	// One transfer at a time, lowest pending kind first
	always_ff @(posedge clock or posedge rst) begin
		if (rst || soft_q) begin
			st_q <= ST_IDLE;
			kind_q <= XK_LIN;
			chan_q <= 2'h0;
		end else begin
			unique case (st_q)
				ST_IDLE: begin
					if (|busy) begin
						chan_q <= pick_chan;
						kind_q <= first_set(pend_q[pick_chan]); // [R18]
						st_q <= ST_ISSUE;
					end
				end
				ST_ISSUE: st_q <= ST_WAIT;
				ST_WAIT: begin
					if (xfer_done)
						st_q <= ST_IDLE;
				end
				default: st_q <= ST_IDLE;
			endcase
		end
	end

	assign xfer_valid = st_q == ST_ISSUE;
	assign xfer_kind = kind_q;
	assign xfer_chan = chan_q;

	////////////////////////////////////////////////////////////////////////
	// Read path

	logic [15:0] rd_word;

	// Per-channel reads give zero when no channel is pointed at
	always_comb begin
		rd_word = 16'h0000; // [R24]
		unique case (addr_q)
			OFS_ACTIVITY: rd_word[3:0] = act_q; // [R1]
			OFS_SOFT: rd_word[SOFT_BIT] = soft_q;
			OFS_PATTERN: rd_word[PAT_BIT] = pat_sel_q;
			OFS_STARTUP: rd_word[3:0] = dly_q;
			OFS_POINTER: rd_word[2:0] = ptr_q;
			OFS_CAL: rd_word[7:0] = sel_ok ? cal_q[sel_idx] : 8'h00; // [R11]
			OFS_MAILBOX: rd_word[0] = sel_ok && busy[sel_idx]; // [R19] [R9]
			OFS_RUN: rd_word[0] = sel_ok && act_q[sel_idx]; // [R21]
			default: rd_word = 16'h0000;
		endcase
	end

	// Answer is held until the next read, which the link paces
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			rdata_hold_q <= 16'h0000;
			ack_tgl_q <= 1'b0;
		end else if (rd_ev) begin
			rdata_hold_q <= rd_word;
			ack_tgl_q <= rd_sync_q[2] ^ 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Start-up delay and test pattern

	logic run_q;
	logic [3:0] dly_cnt_q;
	logic [7:0] ramp_q;
	logic [3:0] flash_q;
	logic [7:0] pat_word;

	// Alignment restarts the cores after the programmed delay
	always_ff @(posedge clock or posedge rst) begin
		if (rst || soft_q) begin
			run_q <= 1'b0;
			dly_cnt_q <= DLY_RST;
		end else if (al_ev) begin
			run_q <= 1'b0;
			dly_cnt_q <= dly_q; // [R7]
		end else if (!run_q) begin
			if (dly_cnt_q == 4'h0)
				run_q <= 1'b1;
			else
				dly_cnt_q <= dly_cnt_q - 4'h1; // [R7]
		end
	end

	assign core_started = run_q;

	// Generators reset on alignment so all four lanes line up
	always_ff @(posedge clock or posedge rst) begin
		if (rst || soft_q || al_ev) begin
			ramp_q <= 8'h00;
			flash_q <= 4'h0;
		end else if (run_q) begin
			ramp_q <= ramp_q + 8'h01;
			flash_q <= (flash_q == FLASH_LAST) ? 4'h0 : flash_q + 4'h1;
		end
	end

	assign pat_word = pat_sel_q ? ((flash_q == FLASH_LAST) ? FLASH_ON
		: 8'h00) : ramp_q; // [R6]

	always_ff @(posedge clock or posedge rst) begin
		if (rst || soft_q)
			test_lanes <= 32'h0;
		else if (pattern_mode_en && run_q)
			test_lanes <= {4{pat_word}}; // [R4] [R6]
		else
			test_lanes <= 32'h0; // [R4]
	end

	////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	property p_soft_self_clear;
		soft_q |=> !soft_q;
	endproperty
	a_soft_self_clear: assert property (p_soft_self_clear) // [R3]
		else $error("soft clear did not drop");

	property p_soft_clears;
		soft_q |=> ptr_q == PTR_RST && !pat_sel_q && dly_q == DLY_RST
			&& busy == 4'h0 && !core_started;
	endproperty
	a_soft_clears: assert property (p_soft_clears) // [R2]
		else $error("soft clear left state behind");

	property p_standby_all;
		standby_select == SB_ALL |=> core_active_flags == 4'h0;
	endproperty
	a_standby_all: assert property (p_standby_all) // [R22]
		else $error("full standby shows an active core");

	property p_active_all;
		standby_select == SB_NONE && !soft_q && !rst
			|=> core_active_flags == 4'hf;
	endproperty
	a_active_all: assert property (p_active_all) // [R1]
		else $error("no standby but a core reads idle");

	property p_busy_ignore;
		wr_ev && addr_q == OFS_CAL && sel_ok && busy[sel_idx]
			&& !(st_q == ST_WAIT && xfer_done) |=> busy == $past(busy);
	endproperty
	a_busy_ignore: assert property (p_busy_ignore) // [R20]
		else $error("launch to busy channel was taken");

	property p_launch_busy;
		cal_wr && cal_mask(wdata_q[7:0]) != 4'h0
			|=> busy[$past(sel_idx)] ##1 busy[$past(sel_idx, 2)];
	endproperty
	a_launch_busy: assert property (p_launch_busy) // [R16]
		else $error("launch did not raise busy");

	property p_order;
		xfer_valid |-> (pend_q[xfer_chan]
			& 4'((4'h1 << xfer_kind) - 4'h1)) == 4'h0;
	endproperty
	a_order: assert property (p_order) // [R18]
		else $error("transfer issued out of order");

	property p_no_chan;
		rd_ev && !sel_ok && (addr_q == OFS_MAILBOX || addr_q == OFS_CAL
			|| addr_q == OFS_RUN) |=> rdata_hold_q == 16'h0000;
	endproperty
	a_no_chan: assert property (p_no_chan) // [R9]
		else $error("per-channel read without channel not zero");

	property p_pattern_off;
		!pattern_mode_en |=> test_lanes == 32'h0;
	endproperty
	a_pattern_off: assert property (p_pattern_off) // [R4]
		else $error("pattern out while pattern mode off");

	property p_startup;
		al_ev && dly_q == 4'h2 ##1 (!al_ev && !soft_q) [*3]
			|-> !core_started ##1 core_started;
	endproperty
	a_startup: assert property (p_startup) // [R7]
		else $error("start-up delay count wrong");

endmodule : asc_reg_bank

/* common/asc_pkg.sv */
package asc_pkg;

	// Register offsets on the serial link (7-bit address space)
	localparam logic [6:0] OFS_ACTIVITY = 7'h02;
	localparam logic [6:0] OFS_SOFT = 7'h04;
	localparam logic [6:0] OFS_PATTERN = 7'h05;
	localparam logic [6:0] OFS_STARTUP = 7'h06;
	localparam logic [6:0] OFS_POINTER = 7'h0f;
	localparam logic [6:0] OFS_CAL = 7'h10;
	localparam logic [6:0] OFS_MAILBOX = 7'h11;
	localparam logic [6:0] OFS_RUN = 7'h12;

	// Field positions
	localparam int SOFT_BIT = 0;
	localparam int PAT_BIT = 0;
	localparam int CAL_LIN_LSB = 0;
	localparam int CAL_OFF_LSB = 2;
	localparam int CAL_GAIN_LSB = 4;
	localparam int CAL_PHASE_LSB = 6;
	localparam logic [1:0] CAL_LOAD_CODE = 2'h2;

	// Reset values
	localparam logic SOFT_RST = 1'b0;
	localparam logic PAT_RST = 1'b0;
	localparam logic [3:0] DLY_RST = 4'h0;
	localparam logic [2:0] PTR_RST = 3'h0;
	localparam logic [7:0] CAL_RST = 8'h00;

	// Channel pointer codes
	localparam logic [2:0] PTR_A = 3'h1;
	localparam logic [2:0] PTR_D = 3'h4;

	// Standby select codes
	localparam logic [1:0] SB_NONE = 2'h0;
	localparam logic [1:0] SB_AB = 2'h1;
	localparam logic [1:0] SB_CD = 2'h2;
	localparam logic [1:0] SB_ALL = 2'h3;

	// Serial frame: 1 r/w bit, 7 address bits, 8 turnaround, 16 data
	localparam logic [5:0] SPI_CMD_LAST = 6'h07;
	localparam logic [5:0] SPI_TURN_LAST = 6'h0f;
	localparam logic [5:0] SPI_DATA_FIRST = 6'h10;
	localparam logic [5:0] SPI_LAST = 6'h1f;
	localparam logic [5:0] SPI_FRAME_BITS = 6'h20;

	// Test pattern: ten zero words, then one all-ones word
	localparam logic [3:0] FLASH_LAST = 4'ha;
	localparam logic [7:0] FLASH_ON = 8'hff;

	// Transfer kinds, numbered in service order
	localparam logic [1:0] XK_LIN = 2'h0;
	localparam logic [1:0] XK_GAIN = 2'h1;
	localparam logic [1:0] XK_OFF = 2'h2;
	localparam logic [1:0] XK_PHASE = 2'h3;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_ISSUE = 3'b010,
		ST_WAIT = 3'b100
	} asc_xfer_st_t;

endpackage : asc_pkg

/* testbench/asc_spi_host.sv */
`timescale 1ns/100ps
// Host end of the serial link: sclk rests low between frames
module asc_spi_host (
	// Link outputs
	output logic sclk,
	output logic cs_n,
	output logic mosi,
	// Device answer
	input logic miso_o,
	input logic miso_oe
);
	logic last_q;

	// Idle levels at time zero
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		mosi = 1'b0;
		last_q = 1'b0;
	end

	////////////////////////////////////////
	// One frame of 32 rising edges, 160 ns period; mosi moves on the
	// falling edge so it is settled at the device's sampling edge
	task automatic xfer(input logic rw, input logic [6:0] adr,
		input logic [15:0] wd, output logic [15:0] rd);
		logic [31:0] bits;
		logic seen;
		bits = {rw, adr, 8'h00, wd};
		rd = 16'h0000;
		cs_n = 1'b0;
		for (int i = 0; i < 32; i++) begin
			mosi = bits[31 - i];
			#80 sclk = 1'b1;
			#80 sclk = 1'b0;
			// A released line shows the inverse, so it never matches
			seen = miso_oe ? miso_o : ~last_q;
			last_q = seen;
			if (i >= 15 && i < 31)
				rd[30 - i] = seen;
		end
		#80 cs_n = 1'b1;
		mosi = ~mosi;
		// Gap lets the write land in the core before the next frame
		#250;
	endtask : xfer
endmodule : asc_spi_host

/* testbench/tb_adc_status_cal_registers.sv */
`timescale 1ns/100ps
module tb_adc_status_cal_registers
	import asc_pkg::*;
;
	typedef struct packed {
		logic [1:0] sb;
		logic rw;
		logic [6:0] adr;
		logic [15:0] dat;
	} asc_row_t;

	logic clock = 1'b0;
	logic rst = 1'b1;
	logic sclk, cs_n, mosi, miso_o, miso_oe;
	logic pattern_mode_en = 1'b0;
	logic [1:0] standby_select = 2'h0;
	logic [3:0] channel_config = 4'h0;
	logic align_pulse_pos = 1'b0;
	logic align_pulse_neg = 1'b0;
	logic xfer_valid, xfer_done = 1'b0;
	logic [1:0] xfer_kind, xfer_chan;
	logic [3:0] core_active_flags;
	logic core_started;
	logic [31:0] test_lanes;
	logic hold_q = 1'b0;
	int cnt_q = 0;
	logic [3:0] xq [$];
	int mismatches = 0;
	int total_checks = 0;

	// Standby select, then read or write; dat is the expected value on reads
	asc_row_t rows [19] = '{
		'{2'h0, 1'b1, 7'h04, 16'h0000}, '{2'h0, 1'b1, 7'h02, 16'h000f},
		'{2'h1, 1'b1, 7'h02, 16'h000c}, '{2'h2, 1'b1, 7'h02, 16'h0003},
		'{2'h3, 1'b1, 7'h02, 16'h0000}, '{2'h0, 1'b0, 7'h02, 16'hffff},
		'{2'h0, 1'b1, 7'h02, 16'h000f}, '{2'h0, 1'b0, 7'h05, 16'hffff},
		'{2'h0, 1'b1, 7'h05, 16'h0001}, '{2'h0, 1'b0, 7'h06, 16'hffff},
		'{2'h0, 1'b1, 7'h06, 16'h000f}, '{2'h0, 1'b0, 7'h0f, 16'hffff},
		'{2'h0, 1'b1, 7'h0f, 16'h0007}, '{2'h0, 1'b1, 7'h12, 16'h0000},
		'{2'h0, 1'b0, 7'h0f, 16'h0003}, '{2'h1, 1'b1, 7'h12, 16'h0001},
		'{2'h2, 1'b1, 7'h12, 16'h0000}, '{2'h0, 1'b1, 7'h7f, 16'h0000},
		'{2'h0, 1'b1, 7'h11, 16'h0000}
	};

	// Core clock, 50 ns period
	always #25 clock = ~clock;

	asc_reg_bank dut (
		.clock(clock), .rst(rst), .sclk(sclk), .cs_n(cs_n), .mosi(mosi),
		.miso_o(miso_o), .miso_oe(miso_oe),
		.pattern_mode_en(pattern_mode_en), .standby_select(standby_select),
		.channel_config(channel_config), .align_pulse_pos(align_pulse_pos),
		.align_pulse_neg(align_pulse_neg), .xfer_valid(xfer_valid),
		.xfer_kind(xfer_kind), .xfer_chan(xfer_chan), .xfer_done(xfer_done),
		.core_active_flags(core_active_flags), .core_started(core_started),
		.test_lanes(test_lanes)
	);

	asc_spi_host host (
		.sclk(sclk), .cs_n(cs_n), .mosi(mosi),
		.miso_o(miso_o), .miso_oe(miso_oe)
	);

	////////////////////////////////////////
	// Value logic stand-in: logs each request, answers three cycles
	// later, or holds the answer back while hold_q is set
	always @(posedge clock) begin
		xfer_done <= !hold_q && cnt_q == 1 && xfer_valid !== 1'b1;
		if (xfer_valid === 1'b1) begin
			xq.push_back({xfer_chan, xfer_kind});
			cnt_q <= 3;
		end else if (!hold_q && cnt_q != 0)
			cnt_q <= cnt_q - 1;
	end

	////////////////////////////////////////
	task automatic conclude();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : conclude

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED at %0t seen %h expected %h", $time, seen,
				exp);
		end
	endtask : chk

	// Sample one step after the edge so the edge's updates have landed
	task automatic tick();
		@(posedge clock);
		#1;
	endtask : tick

	task automatic wr(input logic [6:0] a, input logic [15:0] d);
		logic [15:0] r;
		host.xfer(1'b0, a, d, r);
	endtask : wr

	task automatic rdchk(input logic [6:0] a, input logic [15:0] e);
		logic [15:0] r;
		host.xfer(1'b1, a, 16'h0000, r);
		chk({16'h0000, r}, {16'h0000, e});
	endtask : rdchk

	task automatic wait_lvl(input logic lvl, output int n);
		n = 0;
		while (core_started !== lvl) begin
			tick();
			n++;
			if (n > 300) begin
				chk({31'h0, core_started}, {31'h0, lvl});
				conclude();
			end
		end
	endtask : wait_lvl

	// Waits for k logged requests, then lets the last answer settle
	task automatic wait_xfers(input int k);
		int n;
		n = 0;
		while (xq.size() < k) begin
			tick();
			n++;
			if (n > 300) begin
				chk(32'(xq.size()), 32'(k));
				conclude();
			end
		end
		repeat (8) tick();
		chk(32'(xq.size()), 32'(k));
	endtask : wait_xfers

	// Activity flags expected for a standby select code
	function automatic logic [3:0] act(input logic [1:0] sb);
		case (sb)
			2'h1: act = 4'hc;
			2'h2: act = 4'h3;
			2'h3: act = 4'h0;
			default: act = 4'hf;
		endcase
	endfunction : act

	////////////////////////////////////////
	initial begin
		int n;
		logic [31:0] prev;
		repeat (2) @(posedge clock);
		rst <= 1'b0;
		repeat (3) tick();
		foreach (rows[i]) begin
			@(posedge clock);
			standby_select <= rows[i].sb;
			repeat (2) tick();
			chk({28'h0, core_active_flags}, {28'h0, act(rows[i].sb)});
			if (rows[i].rw)
				rdchk(rows[i].adr, rows[i].dat);
			else
				wr(rows[i].adr, rows[i].dat);
		end
		$display("register table done");
		// Writing 0 to the soft bit must leave settings alone
		wr(OFS_PATTERN, 16'h0001);
		wr(OFS_POINTER, 16'h0002);
		wr(OFS_SOFT, 16'h0000);
		rdchk(OFS_PATTERN, 16'h0001);
		wr(OFS_SOFT, 16'h0001);
		rdchk(OFS_SOFT, 16'h0000);
		rdchk(OFS_PATTERN, 16'h0000);
		rdchk(OFS_POINTER, 16'h0000);
		rdchk(OFS_STARTUP, 16'h0000);
		$display("soft clear done");
		// All four loads on channel B, answers held back to keep it busy
		hold_q <= 1'b1;
		wr(OFS_POINTER, 16'h0002);
		wr(OFS_CAL, 16'h00aa);
		rdchk(OFS_MAILBOX, 16'h0001);
		wr(OFS_CAL, 16'h0002);
		rdchk(OFS_CAL, 16'h00aa);
		@(posedge clock);
		hold_q <= 1'b0;
		wait_xfers(4);
		for (int k = 0; k < 4; k++)
			chk({28'h0, xq[k]}, {28'h0, 2'h1, 2'(k)});
		rdchk(OFS_MAILBOX, 16'h0000);
		rdchk(OFS_CAL, 16'h00aa);
		// Forbidden and idle codes on channel A start nothing
		xq.delete();
		wr(OFS_POINTER, 16'h0001);
		wr(OFS_CAL, 16'h0031);
		wait_xfers(0);
		wr(OFS_CAL, 16'h0098);
		wait_xfers(2);
		chk({28'h0, xq[0]}, {28'h0, 4'h2});
		chk({28'h0, xq[1]}, {28'h0, 4'h3});
		rdchk(OFS_CAL, 16'h0098);
		wr(OFS_POINTER, 16'h0002);
		rdchk(OFS_CAL, 16'h00aa);
		// No channel selected: the launch is dropped
		xq.delete();
		wr(OFS_POINTER, 16'h0000);
		wr(OFS_CAL, 16'h0002);
		wait_xfers(0);
		rdchk(OFS_CAL, 16'h0000);
		$display("calibration launch done");
		// Pattern mode on, then align so the cores start
		@(posedge clock);
		pattern_mode_en <= 1'b1;
		align_pulse_pos <= 1'b1;
		wait_lvl(1'b1, n);
		for (int d = 0; d < 16; d += (d == 0) ? 2 : 13) begin
			@(posedge clock);
			align_pulse_pos <= 1'b0;
			wr(OFS_STARTUP, 16'(d));
			@(posedge clock);
			align_pulse_pos <= 1'b1;
			wait_lvl(1'b0, n);
			wait_lvl(1'b1, n);
			chk(32'(n), 32'(d + 1));
		end
		tick();
		prev = test_lanes;
		tick();
		chk(test_lanes, {4{prev[7:0] + 8'h01}});
		wr(OFS_PATTERN, 16'h0001);
		n = 0;
		while (test_lanes[7:0] !== 8'hff && n < 12) begin
			tick();
			n++;
		end
		chk({24'h0, test_lanes[7:0]}, 32'hff);
		for (int k = 1; k < 12; k++) begin
			tick();
			chk(test_lanes, (k == 11) ? 32'hffffffff : 32'h0);
		end
		@(posedge clock);
		pattern_mode_en <= 1'b0;
		align_pulse_pos <= 1'b0;
		@(posedge clock);
		align_pulse_pos <= 1'b1;
		repeat (3) tick();
		chk(test_lanes, 32'h0);
		$display("test pattern done");
		// Interleaved mode with A and B standby idles every core
		@(posedge clock);
		align_pulse_pos <= 1'b0;
		channel_config <= 4'h8;
		standby_select <= SB_AB;
		repeat (2) tick();
		chk({28'h0, core_active_flags}, 32'h0);
		// Mid-run reset: outputs low while held, defaults after release
		@(posedge clock);
		channel_config <= 4'h0;
		standby_select <= SB_NONE;
		rst <= 1'b1;
		repeat (2) tick();
		chk({core_active_flags, 27'h0, core_started}, 32'h0);
		@(posedge clock);
		rst <= 1'b0;
		repeat (3) tick();
		chk({28'h0, core_active_flags}, 32'hf);
		rdchk(OFS_POINTER, 16'h0000);
		rdchk(OFS_RUN, 16'h0000);
		$display("reset and mode done");
		conclude();
	end
endmodule : tb_adc_status_cal_registers
